// File: pkg/mci_defines.svh
`ifndef MCI_DEFINES_SVH
`define MCI_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define MCI_NUM_AXES 2
`define MCI_QDEPTH 8
`define MCI_MACROS 25
`define MCI_MACRO_MAX 32'h0000_0018

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MCI_OFF_CMD 8'h00
`define MCI_OFF_ARG1 8'h04
`define MCI_OFF_ARG2 8'h08
`define MCI_OFF_STATUS 8'h0C
`define MCI_OFF_CTRL 8'h10
`define MCI_OFF_SETTLE 8'h14
`define MCI_OFF_QUERY 8'h18
`define MCI_OFF_CONTOUR 8'h1C
`define MCI_OFF_MSTORE 8'h20
// Axis block base; axis a at base + 0x10*a, four words each
`define MCI_AXIS_BASE 2'b01

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MCI_ERR_RANGE 0
`define MCI_ERR_FULL 1
`define MCI_ERR_MACRO 2
`define MCI_CTRL_RAMP_LSB 8
`define MCI_ACCEL_RST 32'h0000_0100
`define MCI_SETTLE_RST 16'h0000

// ----------------------------------------------------------------
// Limits
// ----------------------------------------------------------------
`define MCI_VEL_MAX 32'h003D_0900
`define MCI_POS_MIN 32'hF000_0000
`define MCI_POS_MAX 32'h0FFF_FFFF

// ----------------------------------------------------------------
// Queue entry costs
// ----------------------------------------------------------------
`define MCI_STAIR_CMD 4'h2
`define MCI_STAIR_ARG 4'h2
`define MCI_STAIR_PA_CMD 4'h1
`define MCI_STAIR_ENC_CMD 4'h2
`define MCI_PA_CMD 4'h1
`define MCI_PA_SET_CMD 4'h2
`define MCI_PA_SET_ARG 4'h1
`define MCI_LIN_CMD 4'h5
`define MCI_LIN_ARG 4'h6
`define MCI_ONE 4'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCI_TICK_US 32'h0000_03E8
`define MCI_CLK_MHZ 32'h0000_0014

`endif

// File: pkg/mci_pkg.sv
package mci_pkg;
`include "mci_defines.svh"

typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_STAIR = 4'h1,
    OP_STOP = 4'h2,
    OP_DIR_POS = 4'h3,
    OP_DIR_NEG = 4'h4,
    OP_LAUNCH = 4'h5,
    OP_AUTO = 4'h6,
    OP_HIGH = 4'h7,
    OP_LOW = 4'h8,
    OP_AUX_ON = 4'h9,
    OP_AUX_OFF = 4'hA,
    OP_LINEAR = 4'hB,
    OP_ACCEL = 4'hC,
    OP_MACRO = 4'hD,
    OP_NV = 4'hE,
    OP_QUERY = 4'hF
} mci_op_type;

// Encoder report shares the query code with axis field and arg1 bit 0 set
typedef enum logic [5:0] {
    AX_IDLE = 6'h01,
    AX_STAIR = 6'h02,
    AX_CRUISE = 6'h04,
    AX_LAUNCH = 6'h08,
    AX_SETTLE = 6'h10,
    AX_STOP = 6'h20
} mci_axmode_type;

typedef struct packed {
    mci_op_type op;
    logic [0:0] axis;
    logic signed [31:0] arg1;
    logic [31:0] arg2;
    logic [3:0] ccost;
    logic [3:0] acost;
} mci_qent_type;

typedef struct packed {
    mci_axmode_type mode;
    logic signed [31:0] pos;
    logic [31:0] vel;
    logic [31:0] vtgt;
    logic signed [31:0] tgt;
    logic [31:0] accel;
    logic dir;
    logic aux;
    logic pa_en;
    logic pa_inv;
    logic [15:0] scnt;
} mci_axis_type;

typedef struct packed {
    mci_axis_type [`MCI_NUM_AXES-1:0] ax;
    mci_qent_type [`MCI_QDEPTH-1:0] q;
    mci_qent_type [`MCI_MACROS-1:0] mac;
    logic [3:0] qcnt;
    logic [7:0] cmd_used;
    logic [7:0] arg_used;
    logic [31:0] arg1;
    logic [31:0] arg2;
    logic [15:0] settle;
    logic [`MCI_NUM_AXES-1:0] enc_axis;
    logic [`MCI_NUM_AXES-1:0] ramp_nonlin;
    logic [2:0] err;
    logic [3:0] qry;
    logic [`MCI_NUM_AXES-1:0][31:0] enc_snap;
    logic nv_v;
    logic [31:0] nv_val;
    logic [31:0] cvel;
    mci_qent_type mx;
    logic mx_v;
    logic [15:0] tick;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
} mci_state_type;

endpackage

// File: design/mci_top.sv
// Functional notes
// - Staircase drives axis to absolute target, then next queued entry runs.
// - No follow-on at breakpoint: axis keeps last velocity.
// - Target already passed: no reversal, old velocity kept.
// - Staircase ramps linearly at set acceleration, ramp type ignored.
// - Velocity 1..4,000,000 and position inside range, else refused.
// - Staircase costs 2/2 entries, +1 command with auto, +2 encoder.
// - Macro run issues stored entry in the next free cycle; index 0..24 only.
// - Contour override applies unramped at next contour entry.
// - Override ignored without running contour; range 1..4,000,000.
// - Auto mode: aux high in launch move, low after; nonzero inverts.
// - Settle time delays aux complement after move end.
// - Auto mode off at reset; aux on/off/high/low cancel it.
// - Auto enable acts at once and queues aux idle-level entry.
// - Auto costs 1/0 entries, plus 2/1 when settle set.
// - Auto query reports enable and move level immediately.
// - Encoder report captures all axes immediately, any mode.
// - Linear restore sets all axes linear; costs 5/6 entries.
// - Set-high drives aux high, cancels auto, costs 1/0.
// - Direction-positive sets direction output for later moves.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
module mci_top
    import mci_pkg::*;
#(
    parameter int TICK_CYCLES = `MCI_TICK_US * `MCI_CLK_MHZ
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`MCI_NUM_AXES-1:0][31:0] enc_pos,
    input wire logic contour_running,
    input wire logic contour_next,
    output logic [`MCI_NUM_AXES-1:0] aux_out,
    output logic [`MCI_NUM_AXES-1:0] dir_out,
    output logic [31:0] contour_vel
);

localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
localparam int NA = `MCI_NUM_AXES;
localparam int QD = `MCI_QDEPTH;

mci_state_type s;
mci_state_type n;
mci_qent_type iss;
mci_qent_type h;
mci_axis_type a;
logic iss_v;
logic acc_wr;
logic tick;
logic push;
logic pop;
logic hit;
logic [31:0] rd;
logic [2:0] err_set;
logic [2:0] err_clr;
logic [32:0] sum;
logic passed;
logic [3:0] idx;

// ----------------------------------------------------------------
// Next state
// ----------------------------------------------------------------
always_comb
begin
    n = s;
    n.ready = 1'b0;
    n.slverr = 1'b0;
    err_set = 3'h0;
    err_clr = 3'h0;
    push = 1'b0;
    pop = 1'b0;
    iss = '0;
    iss_v = 1'b0;
    h = s.q[0];
    a = s.ax[h.axis];
    sum = 33'h0_0000_0000;
    passed = 1'b0;
    idx = 4'h0;
    tick = (s.tick == TICK_LAST);
    n.tick = tick ? 16'h0000 : s.tick + 16'h0001;
    acc_wr = psel && penable && s.ready && pwrite;

    // No wait state: answer prepared in the setup cycle
    hit = 1'b1;
    rd = 32'h0000_0000;
    if (paddr[7:6] == `MCI_AXIS_BASE)
    begin
        hit = ({1'b0, paddr[5:4]} < 3'(NA));
        unique case (paddr[3:2])
            2'b00: rd = s.ax[paddr[4]].pos;
            2'b01: rd = s.ax[paddr[4]].vel;
            2'b10: rd = {22'h00_0000, s.ax[paddr[4]].mode,
                s.ax[paddr[4]].pa_inv, s.ax[paddr[4]].pa_en,
                s.ax[paddr[4]].aux, s.ax[paddr[4]].dir};
            2'b11: rd = s.enc_snap[paddr[4]];
        endcase
    end
    else
    begin
        case (paddr)
            `MCI_OFF_ARG1: rd = s.arg1;
            `MCI_OFF_ARG2: rd = s.arg2;
            `MCI_OFF_STATUS: rd = {8'h00, s.cmd_used, s.arg_used,
                s.mx_v, s.qcnt, s.err};
            `MCI_OFF_CTRL: rd = {22'h00_0000, s.ramp_nonlin,
                6'h00, s.enc_axis};
            `MCI_OFF_SETTLE: rd = {16'h0000, s.settle};
            `MCI_OFF_QUERY: rd = {28'h000_0000, s.qry};
            `MCI_OFF_CONTOUR: rd = s.cvel;
            `MCI_OFF_CMD, `MCI_OFF_MSTORE: rd = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
    end
    if (psel && !penable)
    begin
        n.ready = 1'b1;
        n.slverr = !hit;
        n.rdata = rd;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    if (acc_wr)
    begin
        case (paddr)
            `MCI_OFF_CMD:
            begin
                iss.op = mci_op_type'(pwdata[3:0]);
                iss.axis = pwdata[4];
                iss.arg1 = s.arg1;
                iss.arg2 = s.arg2;
                iss_v = 1'b1;
            end
            `MCI_OFF_ARG1: n.arg1 = pwdata;
            `MCI_OFF_ARG2: n.arg2 = pwdata;
            `MCI_OFF_STATUS: err_clr = pwdata[2:0];
            `MCI_OFF_CTRL:
            begin
                n.enc_axis = pwdata[NA-1:0];
                n.ramp_nonlin =
                    pwdata[`MCI_CTRL_RAMP_LSB+NA-1:`MCI_CTRL_RAMP_LSB];
            end
            `MCI_OFF_SETTLE: n.settle = pwdata[15:0];
            `MCI_OFF_MSTORE:
            begin
                if (pwdata[12:8] <= 5'(`MCI_MACRO_MAX))
                begin
                    n.mac[pwdata[12:8]].op = mci_op_type'(pwdata[3:0]);
                    n.mac[pwdata[12:8]].axis = pwdata[4];
                    n.mac[pwdata[12:8]].arg1 = s.arg1;
                    n.mac[pwdata[12:8]].arg2 = s.arg2;
                end
                else
                    err_set[`MCI_ERR_MACRO] = 1'b1;
            end
            default: ;
        endcase
    end

    // Host command wins; a pending macro entry issues next free cycle
    if (!iss_v && s.mx_v)
    begin
        iss = s.mx;
        iss_v = 1'b1;
        n.mx_v = 1'b0;
    end

    // ------------------------------------------------------------
    // Axis motion
    // ------------------------------------------------------------
    for (int i = 0; i < NA; i++)
    begin
        if (tick)
        begin
            sum = {1'b0, s.ax[i].vel} + {1'b0, s.ax[i].accel};
            // Always linear steps, whatever ramp type is set
            if (s.ax[i].vel < s.ax[i].vtgt)
                n.ax[i].vel = (sum > {1'b0, s.ax[i].vtgt}) ?
                    s.ax[i].vtgt : sum[31:0];
            else if (s.ax[i].vel > s.ax[i].vtgt)
                n.ax[i].vel = (s.ax[i].vel - s.ax[i].vtgt >
                    s.ax[i].accel) ? s.ax[i].vel - s.ax[i].accel :
                    s.ax[i].vtgt;
            if (s.ax[i].mode != AX_IDLE && s.ax[i].mode != AX_SETTLE)
                n.ax[i].pos = s.ax[i].dir ?
                    s.ax[i].pos + $signed(s.ax[i].vel) :
                    s.ax[i].pos - $signed(s.ax[i].vel);
        end
        passed = s.ax[i].dir ? (s.ax[i].pos >= s.ax[i].tgt) :
            (s.ax[i].pos <= s.ax[i].tgt);
        unique case (s.ax[i].mode)
            AX_IDLE, AX_CRUISE: ;
            // Breakpoint: free the queue, keep velocity
            AX_STAIR:
                if (passed)
                    n.ax[i].mode = AX_CRUISE;
            AX_LAUNCH:
                if (passed)
                begin
                    n.ax[i].vel = 32'h0000_0000;
                    n.ax[i].vtgt = 32'h0000_0000;
                    if (s.ax[i].pa_en && s.settle != 16'h0000)
                    begin
                        n.ax[i].mode = AX_SETTLE;
                        n.ax[i].scnt = s.settle;
                    end
                    else
                    begin
                        n.ax[i].mode = AX_IDLE;
                        if (s.ax[i].pa_en)
                            n.ax[i].aux = s.ax[i].pa_inv;
                    end
                end
            AX_SETTLE:
                if (s.ax[i].scnt == 16'h0000)
                begin
                    n.ax[i].mode = AX_IDLE;
                    if (s.ax[i].pa_en)
                        n.ax[i].aux = s.ax[i].pa_inv;
                end
                else if (tick)
                    n.ax[i].scnt = s.ax[i].scnt - 16'h0001;
            AX_STOP:
                if (s.ax[i].vel == 32'h0000_0000)
                    n.ax[i].mode = AX_IDLE;
            default: n.ax[i].mode = AX_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Queue head, strictly in arrival order
    // ------------------------------------------------------------
    if (s.qcnt != 4'h0)
    begin
        passed = a.dir ? (a.pos >= h.arg1) : (a.pos <= h.arg1);
        unique case (h.op)
            OP_STAIR, OP_STOP:
                if (a.mode == AX_IDLE || a.mode == AX_CRUISE)
                begin
                    pop = 1'b1;
                    if (h.op == OP_STOP)
                    begin
                        n.ax[h.axis].vtgt = 32'h0000_0000;
                        n.ax[h.axis].mode = AX_STOP;
                    end
                    // Passed target: no reversal, old speed
                    else if (!passed)
                    begin
                        n.ax[h.axis].tgt = h.arg1;
                        n.ax[h.axis].vtgt = h.arg2;
                        n.ax[h.axis].mode = AX_STAIR;
                    end
                end
            OP_LAUNCH:
                if (a.mode == AX_IDLE)
                begin
                    pop = 1'b1;
                    n.ax[h.axis].tgt = h.arg1;
                    n.ax[h.axis].vtgt = h.arg2;
                    n.ax[h.axis].mode = AX_LAUNCH;
                    if (a.pa_en)
                        n.ax[h.axis].aux = !a.pa_inv;
                end
            OP_DIR_POS, OP_DIR_NEG:
            begin
                pop = 1'b1;
                n.ax[h.axis].dir = (h.op == OP_DIR_POS);
            end
            OP_AUTO:
            begin
                pop = 1'b1;
                n.ax[h.axis].aux = a.pa_inv;
            end
            OP_HIGH, OP_AUX_ON, OP_LOW, OP_AUX_OFF:
            begin
                pop = 1'b1;
                n.ax[h.axis].pa_en = 1'b0;
                n.ax[h.axis].aux = (h.op == OP_HIGH ||
                    h.op == OP_AUX_ON);
            end
            OP_LINEAR:
            begin
                pop = 1'b1;
                n.ramp_nonlin = '0;
            end
            OP_ACCEL:
            begin
                pop = 1'b1;
                n.ax[h.axis].accel = h.arg1;
            end
            default: pop = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Issue: immediate ones act now, the rest are queued
    // ------------------------------------------------------------
    if (iss_v)
    begin
        unique case (iss.op)
            OP_MACRO:
                if (iss.arg1 <= `MCI_MACRO_MAX)
                begin
                    n.mx = s.mac[iss.arg1[4:0]];
                    n.mx_v = 1'b1;
                end
                else
                    err_set[`MCI_ERR_MACRO] = 1'b1;
            OP_NV:
                if (iss.arg1 == 32'h0000_0000 ||
                    iss.arg1 > `MCI_VEL_MAX)
                    err_set[`MCI_ERR_RANGE] = 1'b1;
                else if (contour_running)
                begin
                    n.nv_v = 1'b1;
                    n.nv_val = iss.arg1;
                end
            OP_QUERY:
                // Axis bit and arg1 bit 0 both high select the all-axis encoder capture
                if (iss.axis[0] && iss.arg1[0])
                begin
                    n.enc_snap = enc_pos;
                    n.qry[3] = 1'b1;
                end
                else
                    n.qry = {s.qry[3], 1'b1, s.ax[iss.axis].pa_en,
                        s.ax[iss.axis].pa_en &&
                        !s.ax[iss.axis].pa_inv};
            default:
            begin
                push = 1'b1;
                iss.ccost = `MCI_ONE;
                iss.acost = 4'h0;
                if (iss.op == OP_STAIR)
                begin
                    iss.ccost = `MCI_STAIR_CMD;
                    iss.acost = `MCI_STAIR_ARG;
                    if (s.ax[iss.axis].pa_en)
                        iss.ccost = iss.ccost + `MCI_STAIR_PA_CMD;
                    if (s.enc_axis[iss.axis])
                        iss.ccost = iss.ccost + `MCI_STAIR_ENC_CMD;
                    if (iss.arg2 == 32'h0000_0000 ||
                        iss.arg2 > `MCI_VEL_MAX ||
                        $signed(iss.arg1) < $signed(`MCI_POS_MIN) ||
                        $signed(iss.arg1) > $signed(`MCI_POS_MAX))
                    begin
                        push = 1'b0;
                        err_set[`MCI_ERR_RANGE] = 1'b1;
                    end
                end
                else if (iss.op == OP_AUTO)
                begin
                    // Mode switches now, idle level queued
                    n.ax[iss.axis].pa_en = 1'b1;
                    n.ax[iss.axis].pa_inv = (iss.arg1 != 32'h0000_0000);
                    if (s.settle != 16'h0000)
                    begin
                        iss.ccost = `MCI_PA_CMD + `MCI_PA_SET_CMD;
                        iss.acost = `MCI_PA_SET_ARG;
                    end
                end
                else if (iss.op == OP_LINEAR)
                begin
                    iss.ccost = `MCI_LIN_CMD;
                    iss.acost = `MCI_LIN_ARG;
                end
                else if (iss.op == OP_STOP || iss.op == OP_ACCEL ||
                    iss.op == OP_LAUNCH)
                    iss.acost = `MCI_ONE;
                if (push && s.qcnt == 4'(QD) && !pop)
                begin
                    push = 1'b0;
                    err_set[`MCI_ERR_FULL] = 1'b1;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Queue storage and entry accounting
    // ------------------------------------------------------------
    if (pop)
    begin
        for (int i = 0; i < QD - 1; i++)
            n.q[i] = s.q[i+1];
        n.q[QD-1] = '0;
    end
    idx = s.qcnt - {3'h0, pop};
    if (push)
        n.q[idx[2:0]] = iss;
    n.qcnt = s.qcnt + {3'h0, push} - {3'h0, pop};
    n.cmd_used = s.cmd_used + (push ? {4'h0, iss.ccost} : 8'h00)
        - (pop ? {4'h0, h.ccost} : 8'h00);
    n.arg_used = s.arg_used + (push ? {4'h0, iss.acost} : 8'h00)
        - (pop ? {4'h0, h.acost} : 8'h00);

    // ------------------------------------------------------------
    // Contour override
    // ------------------------------------------------------------
    // Stepped in whole, no ramp, on the next contour entry
    if (contour_next && s.nv_v)
    begin
        n.cvel = s.nv_val;
        n.nv_v = 1'b0;
    end
    if (!contour_running)
        n.nv_v = 1'b0;

    // Set beats a same-cycle clear
    n.err = (s.err & ~err_clr) | err_set;
end

// ----------------------------------------------------------------
// State register
// ----------------------------------------------------------------
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        s <= '0;
        for (int i = 0; i < NA; i++)
        begin
            s.ax[i].mode <= AX_IDLE;
            s.ax[i].accel <= `MCI_ACCEL_RST;
            s.ax[i].dir <= 1'b1;
        end
        s.settle <= `MCI_SETTLE_RST;
    end
    else
        s <= n;
end

// ----------------------------------------------------------------
// Outputs
// ----------------------------------------------------------------
always_comb
begin
    for (int i = 0; i < NA; i++)
    begin
        aux_out[i] = s.ax[i].aux;
        dir_out[i] = s.ax[i].dir;
    end
end

assign prdata = s.rdata;
assign pready = s.ready;
assign pslverr = s.slverr;
assign contour_vel = s.cvel;

endmodule // mci_top

// File: dv/mci_top_sva.sv
`timescale 1ns/1ns
module mci_top_sva
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic contour_running,
    input wire logic contour_next,
    input wire logic [31:0] contour_vel
);
// --------------------------------
// Answer and contour relations
// --------------------------------
localparam logic [31:0] VMAX = 32'h003D_0900;
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
answer_timing_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
single_answer_a: assert property (pready |=> !pready)
    else $error("answer held too long");
answer_cause_a: assert property
    (pready |-> $past(psel) && !$past(penable))
    else $error("answer without setup");
error_ready_a: assert property (pslverr |-> pready)
    else $error("error outside answer");
query_mapped_a: assert property
    (psel && !penable && paddr == 8'h18 |=> !pslverr)
    else $error("query place refused");
vel_cause_a: assert property
    ($changed(contour_vel) |-> $past(contour_next))
    else $error("contour speed moved off entry start");
vel_idle_a: assert property
    ($changed(contour_vel) |-> $past(contour_running))
    else $error("contour speed moved while idle");
vel_range_a: assert property
    ($changed(contour_vel) |-> contour_vel inside {[1:VMAX]})
    else $error("contour speed out of range");
endmodule // mci_top_sva

bind mci_top mci_top_sva chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .contour_running(contour_running),
    .contour_next(contour_next), .contour_vel(contour_vel));

// File: dv/mci_field_model.sv
`timescale 1ns/1ns
module mci_field_model
(
    input wire logic pclk,
    input wire logic run_in,
    input wire logic step_in,
    output logic [1:0][31:0] enc_pos,
    output logic contour_running,
    output logic contour_next
);
logic step_reg;
// Negative count on axis 1 exposes sign handling
assign enc_pos = {32'hFFFF_FF00, 32'h0000_1234};
assign contour_running = run_in;
assign contour_next = step_in & ~step_reg;
always_ff @(posedge pclk)
begin
    step_reg <= step_in;
end
endmodule // mci_field_model

// File: dv/tb_mci_top.sv
`timescale 1ns/1ns
module tb_mci_top;
logic pclk, presetn, psel, penable, pwrite, er, run_in, step_in;
logic [7:0] paddr;
logic [31:0] pwdata, prdata, contour_vel, rd;
logic pready, pslverr, contour_running, contour_next;
logic [1:0][31:0] enc_pos;
logic [1:0] aux_out, dir_out;
int fail_count = 0, samples_checked = 0, cyc = 0;
mci_top #(.TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_pos(enc_pos),
    .contour_running(contour_running), .contour_next(contour_next),
    .aux_out(aux_out), .dir_out(dir_out), .contour_vel(contour_vel));
mci_field_model field (.pclk(pclk), .run_in(run_in),
    .step_in(step_in), .enc_pos(enc_pos),
    .contour_running(contour_running), .contour_next(contour_next));
// --------------------------------
// Bus and check helpers
// --------------------------------
initial
begin
    pclk = 0;
    forever #25 pclk = ~pclk;
end
always @(posedge pclk)
begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
        fail_count++;
        complete_run;
    end
end
task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
task check(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
        fail_count++;
        $display("mismatch at %0t: got %h want %h", $time, s, e);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task cmd(input logic ax, input logic [3:0] op, input logic [31:0] a1,
    input logic [31:0] a2);
    apb(1, 8'h04, a1);
    apb(1, 8'h08, a2);
    apb(1, 8'h00, {27'h0, ax, op});
endtask
task waitq;
    int n;
    n = 0;
    apb(0, 8'h0C, 0);
    while (rd[6:3] !== 4'h0 && n < 100)
    begin
        apb(0, 8'h0C, 0);
        n++;
    end
endtask
task poll_aux(input logic v);
    int n;
    n = 0;
    while (aux_out[0] !== v && n < 400)
    begin
        @(posedge pclk);
        n++;
    end
    check(aux_out[0], v);
endtask
task pulse;
    @(posedge pclk) step_in <= 1;
    @(posedge pclk) step_in <= 0;
    repeat (3) @(posedge pclk);
endtask
task reset_dut;
    @(posedge pclk) presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
endtask
// --------------------------------
// Scenarios
// --------------------------------
task t_reset;
    check(dir_out, 2'h3);
    check(aux_out, 2'h0);
    check(contour_vel, 0);
    apb(0, 8'h58, 0);
    check(rd[2], 0);
    apb(0, 8'h10, 0);
    check(rd[9:8], 0);
    $display("reset test done");
endtask
task t_stair;
    int n;
    cmd(0, 4'h3, 0, 0);
    waitq;
    check(dir_out[0], 1);
    cmd(0, 4'h1, 32'h3E8, 32'h3E8);
    n = 0;
    do begin apb(0, 8'h48, 0); n++; end
    while (rd[9:4] !== 6'h04 && n < 60);
    check(rd[9:4], 6'h04);
    apb(0, 8'h44, 0);
    check(rd, 32'h3E8);
    cmd(0, 4'h1, 32'h1F4, 32'h7D0);
    waitq;
    repeat (20) @(posedge pclk);
    apb(0, 8'h44, 0);
    check(rd, 32'h3E8);
    $display("staircase test done");
endtask
task t_range;
    logic [31:0] p[3] = '{32'h64, 32'h64, 32'h1000_0000};
    logic [31:0] v[3] = '{0, 32'h003D_0901, 32'h5};
    foreach (p[i])
    begin
        cmd(0, 4'h1, p[i], v[i]);
        apb(0, 8'h0C, 0);
        check(rd[2:0], 3'h1);
        apb(1, 8'h0C, 32'h7);
    end
    cmd(0, 4'hD, 32'h19, 0);
    apb(0, 8'h0C, 0);
    check(rd[2:0], 3'h4);
    apb(1, 8'h0C, 32'h7);
    cmd(0, 4'hD, 32'h18, 0);
    apb(0, 8'h0C, 0);
    check(rd[2:0], 3'h0);
    apb(0, 8'h30, 0);
    check({er, rd[30:0]}, 32'h8000_0000);
    $display("range test done");
endtask
task t_contour;
    cmd(0, 4'hE, 32'h7530, 0);
    pulse;
    check(contour_vel, 0);
    run_in <= 1;
    cmd(0, 4'hE, 32'h7530, 0);
    repeat (4) @(posedge pclk);
    check(contour_vel, 0);
    pulse;
    check(contour_vel, 32'h7530);
    cmd(0, 4'hE, 32'h003D_0901, 0);
    pulse;
    check(contour_vel, 32'h7530);
    run_in <= 0;
    $display("contour test done");
endtask
task t_macro;
    apb(1, 8'h04, 0);
    apb(1, 8'h08, 0);
    apb(1, 8'h20, 32'h0000_0304);
    cmd(0, 4'hD, 32'h3, 0);
    waitq;
    check(dir_out[0], 0);
    cmd(0, 4'h3, 0, 0);
    waitq;
    check(dir_out[0], 1);
    $display("macro test done");
endtask
task t_auto;
    int n;
    apb(1, 8'h10, 32'h300);
    cmd(0, 4'hB, 0, 0);
    waitq;
    apb(0, 8'h10, 0);
    check(rd[9:8], 0);
    cmd(0, 4'h6, 0, 0);
    waitq;
    check(aux_out[0], 0);
    cmd(0, 4'h5, 32'hC8, 32'h64);
    poll_aux(1);
    poll_aux(0);
    apb(1, 8'h14, 32'hA);
    cmd(0, 4'h6, 1, 0);
    waitq;
    cmd(0, 4'h5, 32'h190, 32'h64);
    poll_aux(0);
    n = 0;
    do begin apb(0, 8'h48, 0); n++; end
    while (rd[9:4] === 6'h08 && n < 100);
    check({rd[9:4], aux_out[0]}, 7'h20);
    cmd(0, 4'h7, 0, 0);
    waitq;
    check(aux_out[0], 1);
    apb(0, 8'h48, 0);
    check(rd[2], 0);
    $display("auto test done");
endtask
task t_costs;
    repeat (2) cmd(1, 4'h1, 32'h0FFF_0000, 32'h64);
    apb(0, 8'h0C, 0);
    check(rd[23:8], 16'h0202);
    cmd(1, 4'h6, 0, 0);
    apb(0, 8'h58, 0);
    check(rd[2], 1);
    apb(0, 8'h0C, 0);
    check(rd[23:8], 16'h0302);
    apb(1, 8'h14, 32'h5);
    cmd(1, 4'h6, 0, 0);
    apb(0, 8'h0C, 0);
    check(rd[23:8], 16'h0603);
    cmd(1, 4'h1, 32'h0FFF_0000, 32'hC8);
    apb(0, 8'h0C, 0);
    check(rd[23:8], 16'h0905);
    apb(1, 8'h10, 32'h2);
    cmd(1, 4'h1, 32'h0FFF_0000, 32'hC8);
    apb(0, 8'h0C, 0);
    check(rd[23:8], 16'h0E07);
    cmd(0, 4'hB, 0, 0);
    apb(0, 8'h0C, 0);
    check(rd[23:8], 16'h130D);
    cmd(1, 4'hF, 0, 0);
    apb(0, 8'h18, 0);
    check(rd[2:0], 3'h7);
    cmd(1, 4'hF, 1, 0);
    apb(0, 8'h18, 0);
    check(rd[3], 1);
    apb(0, 8'h4C, 0);
    check(rd, 32'h0000_1234);
    apb(0, 8'h5C, 0);
    check(rd, 32'hFFFF_FF00);
    repeat (3) cmd(0, 4'h7, 0, 0);
    apb(0, 8'h0C, 0);
    check({rd[6:3], rd[1]}, 5'h11);
    $display("cost test done");
endtask
initial
begin
    {presetn, psel, penable, pwrite, run_in, step_in} = 0;
    paddr = 0;
    pwdata = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_stair;
    t_range;
    t_contour;
    t_macro;
    reset_dut;
    t_auto;
    reset_dut;
    t_costs;
    reset_dut;
    t_reset;
    complete_run;
end
endmodule // tb_mci_top
